/* File: rtl/fuq_counter.sv */
// fast up/down pulse counter and two quadrature encoder counters
// assumes every input is synchronous to clk_i; bounds are signed words
`default_nettype none

// Contract
// - enable input counts only when the release-by-enable option is set
// - count-down low: each counted pulse increments the count
// - count-down high: each counted pulse decrements the count
// - load rising edge copies initial value; flags follow new value
// - clear held high forces the count to zero, zero flag set
// - zero flag is one exactly when the count is zero
// - upper flag set while count is at or above upper bound
// - lower flag set while count at or below lower bound
// - range exceeded flag set when a step would leave signed range
// - on leaving range flags follow the sign of value reached
// - retentive counter keeps its 4-byte count over stop and reset
// - retentive counter resumes from preserved count in run mode
// - two quadrature counters on inputs one-two and three-four
// - quadrature counters count both edges, both directions
// - edge order on channels A and B sets count direction
// - quadrature counters take lower, upper bound and initial value
// - A before B increments on rising or falling edges, reverse down
// - count is a signed 32-bit value read on the count output
// - overrange pulses carry flag one cycle and holds the last count
module fuq_counter (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic fast_count_pulse_i,
  input wire logic fast_count_down_i,
  input wire logic fast_enable_i,
  input wire logic fast_release_by_enable_i,
  input wire logic fast_load_initial_value_i,
  input wire logic fast_clear_count_i,
  input wire logic fast_retentive_i,
  input wire logic [31:0] fast_upper_bound_i,
  input wire logic [31:0] fast_lower_bound_i,
  input wire logic [31:0] fast_initial_value_i,
  input wire logic [3:0] digital_in_i,
  input wire logic [1:0] quad_enable_i,
  input wire logic [1:0] quad_release_by_enable_i,
  input wire logic [1:0] quad_load_initial_value_i,
  input wire logic [1:0] quad_clear_count_i,
  input wire logic [1:0] quad_retentive_i,
  input wire logic [1:0][31:0] quad_upper_bound_i,
  input wire logic [1:0][31:0] quad_lower_bound_i,
  input wire logic [1:0][31:0] quad_initial_value_i,
  output logic [31:0] fast_count_value_o,
  output logic fast_upper_limit_flag_o,
  output logic fast_lower_limit_flag_o,
  output logic fast_zero_flag_o,
  output logic fast_range_exceeded_flag_o,
  output logic [1:0][31:0] quad_count_value_o,
  output logic [1:0] quad_upper_limit_flag_o,
  output logic [1:0] quad_lower_limit_flag_o,
  output logic [1:0] quad_zero_flag_o,
  output logic [1:0] quad_range_exceeded_flag_o
);

  // one step up or down; top bit marks a step that leaves the range
  function automatic logic [32:0] fuq_step(input logic [31:0] v,
                                           input logic up);
    logic [31:0] s;
    logic ovf;
    s = up ? v + fuq_pkg::CNT_ONE : v - fuq_pkg::CNT_ONE;
    ovf = up ? (v == fuq_pkg::CNT_MAX) : (v == fuq_pkg::CNT_MIN);
    return {ovf, s};
  endfunction : fuq_step

  // comparison flags {upper, lower, zero} of a signed count
  function automatic logic [2:0] fuq_flags(input logic [31:0] v,
                                           input logic [31:0] ub,
                                           input logic [31:0] lb);
    logic up_f;
    logic lo_f;
    logic ze_f;
    up_f = $signed(v) >= $signed(ub);
    lo_f = $signed(v) <= $signed(lb);
    ze_f = v == fuq_pkg::CNT_ZERO;
    return {up_f, lo_f, ze_f};
  endfunction : fuq_flags

  // per-slot views of the port groups
  logic [2:0] active_w;
  logic [2:0] load_lvl_w;
  logic [2:0] clear_w;
  logic [2:0] retain_w;
  logic [31:0] ub_w [3];
  logic [31:0] lb_w [3];
  logic [31:0] iv_w [3];
  logic [1:0] quad_a_w;
  logic [1:0] quad_b_w;

  // state
  logic [31:0] count_r [3];
  logic [31:0] count_nxt [3];
  logic [3:0] flags_r [3];
  logic [3:0] flags_nxt [3];
  logic pulse_prev_r;
  logic pulse_prev_nxt;
  logic [1:0] a_prev_r;
  logic [1:0] a_prev_nxt;
  logic [1:0] b_prev_r;
  logic [1:0] b_prev_nxt;
  logic [2:0] load_prev_r;
  logic [2:0] load_prev_nxt;
  logic run_prev_r;
  logic run_prev_nxt;

  // step events and directions per slot
  logic [2:0] step_ev_w;
  logic [2:0] step_up_w;
  logic [2:0] load_edge_w;
  logic stop_edge_w;

  assign quad_a_w = {digital_in_i[fuq_pkg::QUAD1_A_PIN],
                     digital_in_i[fuq_pkg::QUAD0_A_PIN]};
  assign quad_b_w = {digital_in_i[fuq_pkg::QUAD1_B_PIN],
                     digital_in_i[fuq_pkg::QUAD0_B_PIN]};

  assign active_w = {~quad_release_by_enable_i[1] | quad_enable_i[1],
                     ~quad_release_by_enable_i[0] | quad_enable_i[0],
                     ~fast_release_by_enable_i | fast_enable_i};
  assign load_lvl_w = {quad_load_initial_value_i, fast_load_initial_value_i};
  assign clear_w = {quad_clear_count_i, fast_clear_count_i};
  assign retain_w = {quad_retentive_i, fast_retentive_i};

  // bounds and initial value per slot
  assign ub_w[0] = fast_upper_bound_i;
  assign ub_w[1] = quad_upper_bound_i[0];
  assign ub_w[2] = quad_upper_bound_i[1];
  assign lb_w[0] = fast_lower_bound_i;
  assign lb_w[1] = quad_lower_bound_i[0];
  assign lb_w[2] = quad_lower_bound_i[1];
  assign iv_w[0] = fast_initial_value_i;
  assign iv_w[1] = quad_initial_value_i[0];
  assign iv_w[2] = quad_initial_value_i[1];

  assign load_edge_w = load_lvl_w & ~load_prev_r;
  assign stop_edge_w = run_prev_r & ~run_i;

  // edge detection; counting follows pin edges, not any program cycle
  always_comb begin
    logic a_ch;
    logic b_ch;
    a_ch = 1'b0;
    b_ch = 1'b0;
    // rising pulse edge counted, direction from count-down
    step_ev_w[0] = fast_count_pulse_i & ~pulse_prev_r;
    step_up_w[0] = ~fast_count_down_i;
    for (int q = 0; q < fuq_pkg::NUM_QUAD; q++) begin
      a_ch = quad_a_w[q] ^ a_prev_r[q];
      b_ch = quad_b_w[q] ^ b_prev_r[q];
      // every edge on one channel counts; both at once is void
      step_ev_w[q + 1] = a_ch ^ b_ch;
      // A leading B counts up, B leading A counts down
      step_up_w[q + 1] = a_ch ? (quad_a_w[q] != b_prev_r[q])
                              : (quad_b_w[q] == quad_a_w[q]);
    end
  end

  // next values of the edge history; reset takes the live pin levels and
  // holds the run history low so that no false edge is seen right after release
  always_comb begin
    pulse_prev_nxt = fast_count_pulse_i;
    a_prev_nxt = quad_a_w;
    b_prev_nxt = quad_b_w;
    load_prev_nxt = load_lvl_w;
    run_prev_nxt = run_i;
    if (!resetn_i) begin
      run_prev_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    pulse_prev_r <= pulse_prev_nxt;
    a_prev_r <= a_prev_nxt;
    b_prev_r <= b_prev_nxt;
    load_prev_r <= load_prev_nxt;
    run_prev_r <= run_prev_nxt;
  end

  // count and flag update for every slot
  always_comb begin
    logic [32:0] st;
    logic [2:0] cmp;
    logic carry;
    st = 33'h0;
    cmp = 3'h0;
    carry = 1'b0;
    for (int k = 0; k < fuq_pkg::NUM_CTR; k++) begin
      count_nxt[k] = count_r[k];
      carry = 1'b0;
      st = fuq_step(count_r[k], step_up_w[k]);
      if (!resetn_i) begin
        // retentive count survives reset, others go to zero
        count_nxt[k] = retain_w[k] ? count_r[k] : fuq_pkg::CNT_ZERO;
      end else if (clear_w[k]) begin
        // clear held, and it beats a load
        count_nxt[k] = fuq_pkg::CNT_ZERO;
      end else if (load_edge_w[k]) begin
        count_nxt[k] = iv_w[k];
      end else if (run_i && active_w[k] && step_ev_w[k]) begin
        // a step out of range is dropped, count held
        carry = st[32];
        count_nxt[k] = carry ? count_r[k] : st[31:0];
      end else if (stop_edge_w && !retain_w[k]) begin
        // only retentive counts carry over a stop
        count_nxt[k] = fuq_pkg::CNT_ZERO;
      end
      cmp = fuq_flags(count_nxt[k], ub_w[k], lb_w[k]);
      if (carry) begin
        // flags follow the sign of the value that was reached
        cmp = step_up_w[k] ? fuq_pkg::OVR_POS_FLAGS
                           : fuq_pkg::OVR_NEG_FLAGS;
      end
      flags_nxt[k] = {carry, cmp};
    end
  end

  always_ff @(posedge clk_i) begin
    for (int k = 0; k < fuq_pkg::NUM_CTR; k++) begin
      count_r[k] <= count_nxt[k];
      flags_r[k] <= flags_nxt[k];
    end
  end

  // outputs straight from the count and flag registers
  assign fast_count_value_o = count_r[fuq_pkg::FAST_IDX];
  assign fast_upper_limit_flag_o = flags_r[0][fuq_pkg::FLG_UPPER];
  assign fast_lower_limit_flag_o = flags_r[0][fuq_pkg::FLG_LOWER];
  assign fast_zero_flag_o = flags_r[0][fuq_pkg::FLG_ZERO];
  assign fast_range_exceeded_flag_o = flags_r[0][fuq_pkg::FLG_CARRY];
  always_comb begin
    for (int q = 0; q < fuq_pkg::NUM_QUAD; q++) begin
      quad_count_value_o[q] = count_r[q + fuq_pkg::QUAD_BASE];
      quad_upper_limit_flag_o[q] =
        flags_r[q + fuq_pkg::QUAD_BASE][fuq_pkg::FLG_UPPER];
      quad_lower_limit_flag_o[q] =
        flags_r[q + fuq_pkg::QUAD_BASE][fuq_pkg::FLG_LOWER];
      quad_zero_flag_o[q] =
        flags_r[q + fuq_pkg::QUAD_BASE][fuq_pkg::FLG_ZERO];
      quad_range_exceeded_flag_o[q] =
        flags_r[q + fuq_pkg::QUAD_BASE][fuq_pkg::FLG_CARRY];
    end
  end

  // checks on the pulse counter and first quadrature counter
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // a fast step is plain when no clear or load edge interferes
  logic fast_plain_w;
  assign fast_plain_w = run_i && active_w[0] && step_ev_w[0] &&
                        !clear_w[0] && !load_edge_w[0];

  property p_enable_gate;
    fast_release_by_enable_i && !fast_enable_i && !clear_w[0] &&
    !load_edge_w[0] && !stop_edge_w |=> $stable(fast_count_value_o);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("disabled pulse counter changed its count");

  property p_count_up;
    fast_plain_w && !fast_count_down_i &&
    fast_count_value_o != fuq_pkg::CNT_MAX
    |=> fast_count_value_o == $past(fast_count_value_o) + 32'h1;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("up pulse did not add one");

  property p_count_down;
    fast_plain_w && fast_count_down_i &&
    fast_count_value_o != fuq_pkg::CNT_MIN
    |=> fast_count_value_o == $past(fast_count_value_o) - 32'h1;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("down pulse did not subtract one");

  property p_load;
    $rose(fast_load_initial_value_i) && !fast_clear_count_i
    |=> fast_count_value_o == $past(fast_initial_value_i);
  endproperty
  a_load: assert property (p_load)
    else $error("load edge did not copy the initial value");

  property p_clear;
    fast_clear_count_i [*2] |-> fast_count_value_o == fuq_pkg::CNT_ZERO
                               && fast_zero_flag_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("held clear left a nonzero count");

  property p_zero;
    !fast_range_exceeded_flag_o
    |-> fast_zero_flag_o == (fast_count_value_o == fuq_pkg::CNT_ZERO);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with the count");

  property p_upper;
    ##1 !fast_range_exceeded_flag_o |-> fast_upper_limit_flag_o ==
      ($signed(fast_count_value_o) >= $signed($past(fast_upper_bound_i)));
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper flag disagrees with the bound");

  property p_lower;
    ##1 !fast_range_exceeded_flag_o |-> fast_lower_limit_flag_o ==
      ($signed(fast_count_value_o) <= $signed($past(fast_lower_bound_i)));
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower flag disagrees with the bound");

  property p_carry_hold;
    fast_plain_w && !fast_count_down_i &&
    fast_count_value_o == fuq_pkg::CNT_MAX
    |=> fast_range_exceeded_flag_o && fast_upper_limit_flag_o &&
        !fast_zero_flag_o && $stable(fast_count_value_o)
        ##1 !fast_range_exceeded_flag_o || $past(fast_plain_w);
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("overrange did not pulse carry and hold count");

  property p_retain;
    stop_edge_w && fast_retentive_i && !fast_clear_count_i &&
    !load_edge_w[0] |=> $stable(fast_count_value_o);
  endproperty
  a_retain: assert property (p_retain)
    else $error("retentive count lost on stop");

  property p_quad_up;
    run_i && active_w[1] && !clear_w[1] && !load_edge_w[1] &&
    $rose(quad_a_w[0]) && !quad_b_w[0] && $stable(quad_b_w[0]) &&
    quad_count_value_o[0] != fuq_pkg::CNT_MAX
    |=> quad_count_value_o[0] == $past(quad_count_value_o[0]) + 32'h1;
  endproperty
  a_quad_up: assert property (p_quad_up)
    else $error("A leading B did not count up");

  c_carry: cover property (fast_range_exceeded_flag_o);
  c_quad_down: cover property (step_ev_w[1] && !step_up_w[1] && run_i);
  c_load: cover property ($rose(fast_load_initial_value_i));
  c_clear_load: cover property (clear_w[0] && load_edge_w[0]);

endmodule : fuq_counter

`default_nettype wire

/* File: rtl/fuq_pkg.sv */
// constants shared by the fast up/down and quadrature counter block
// assumes a single 40 MHz system clock; all inputs already synchronous
`default_nettype none

package fuq_pkg;

  // count word, signed two's complement
  localparam int CNT_W = 32;
  localparam logic [31:0] CNT_MAX = 32'h7fffffff;
  localparam logic [31:0] CNT_MIN = 32'h80000000;
  localparam logic [31:0] CNT_ZERO = 32'h00000000;
  localparam logic [31:0] CNT_ONE = 32'h00000001;

  // counter slots: slot 0 is the pulse counter, slots 1..2 quadrature
  localparam int NUM_CTR = 3;
  localparam int NUM_QUAD = 2;
  localparam int FAST_IDX = 0;
  localparam int QUAD_BASE = 1;

  // digital input pins wired to the quadrature channels
  localparam int QUAD0_A_PIN = 0;
  localparam int QUAD0_B_PIN = 1;
  localparam int QUAD1_A_PIN = 2;
  localparam int QUAD1_B_PIN = 3;

  // flag word layout inside the block
  localparam int FLG_ZERO = 0;
  localparam int FLG_LOWER = 1;
  localparam int FLG_UPPER = 2;
  localparam int FLG_CARRY = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // forced flag patterns when the range is left {upper,lower,zero}
  localparam logic [2:0] OVR_POS_FLAGS = 3'h4;
  localparam logic [2:0] OVR_NEG_FLAGS = 3'h2;

endpackage : fuq_pkg

`default_nettype wire

/* File: tb/fuq_pulse_src.sv */
// partner model: square-wave pulse source and two quadrature encoders
// assumes the bench calls one task at a time, from a single process
`default_nettype none

module fuq_pulse_src #(
  parameter int HALF = 4000  // half period in clocks; 4000 is 5 kHz
) (
  input wire logic clk_i,
  output logic pulse_o,
  output logic [3:0] quad_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // per-encoder phase index; codes are {b,a} in gray order, a leads
  int pos[2];
  logic [1:0] code[4];

  // lines start low; the pulse line idles low between bursts, encoder lines hold their last code
  initial begin
    pulse_o = 1'b0;
    quad_o = 4'h0;
    pos = '{0, 0};
    code = '{2'h0, 2'h1, 2'h3, 2'h2};
  end

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      pulse_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      pulse_o <= 1'b0;
      repeat (HALF - 1) @(posedge clk_i);
    end
  endtask : pulses

  task automatic quad(input int q, input bit up, input int n);
    repeat (n) begin
      pos[q] = (pos[q] + (up ? 1 : 3)) % 4;
      @(posedge clk_i);
      quad_o[2*q +: 2] <= code[pos[q]];
      repeat (HALF / 2 - 1) @(posedge clk_i);
    end
  endtask : quad

endmodule : fuq_pulse_src

`default_nettype wire

/* File: tb/tb_fast_updown_quadrature_counter.sv */
// self-checking bench for the pulse and quadrature counters
// assumes the partner model drives the pulse and encoder lines
`default_nettype none

module tb_fast_updown_quadrature_counter;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [31:0] iv;
    logic [31:0] ub;
    logic [31:0] lb;
    logic [2:0] f;  // {upper, lower, zero}
  } fuq_row_type;

  logic clk_i = 0;
  logic resetn_i, run_i, dn, en, rel, ld, clr, ret, pulse;
  logic [31:0] ub, lb, iv, cnt, cy_val;
  logic [3:0] din;
  logic [1:0] q_en, q_rel, q_ld, q_clr, q_ret;
  logic [1:0][31:0] q_ub, q_lb, q_iv, q_cnt;
  logic [1:0] q_up, q_lo, q_ze, q_cy;
  logic up_f, lo_f, ze_f, cy_f;
  logic [2:0] cy_flags, q0_f, q1_f;
  int err_count = 0, checks_done = 0, carries = 0, qcarries = 0;
  fuq_row_type rows[5];

  always #12.5 clk_i = ~clk_i;

  // short half period keeps the run brief; rate rule scales with it
  fuq_pulse_src #(.HALF(4)) src (.clk_i(clk_i), .pulse_o(pulse),
    .quad_o(din));

  fuq_counter uut (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run_i),
    .fast_count_pulse_i(pulse), .fast_count_down_i(dn),
    .fast_enable_i(en), .fast_release_by_enable_i(rel),
    .fast_load_initial_value_i(ld), .fast_clear_count_i(clr),
    .fast_retentive_i(ret), .fast_upper_bound_i(ub),
    .fast_lower_bound_i(lb), .fast_initial_value_i(iv),
    .digital_in_i(din), .quad_enable_i(q_en),
    .quad_release_by_enable_i(q_rel), .quad_load_initial_value_i(q_ld),
    .quad_clear_count_i(q_clr), .quad_retentive_i(q_ret),
    .quad_upper_bound_i(q_ub), .quad_lower_bound_i(q_lb),
    .quad_initial_value_i(q_iv), .fast_count_value_o(cnt),
    .fast_upper_limit_flag_o(up_f), .fast_lower_limit_flag_o(lo_f),
    .fast_zero_flag_o(ze_f), .fast_range_exceeded_flag_o(cy_f),
    .quad_count_value_o(q_cnt), .quad_upper_limit_flag_o(q_up),
    .quad_lower_limit_flag_o(q_lo), .quad_zero_flag_o(q_ze),
    .quad_range_exceeded_flag_o(q_cy));

  // quad flag triples in the table's {upper, lower, zero} order
  assign q0_f = {q_up[0], q_lo[0], q_ze[0]};
  assign q1_f = {q_up[1], q_lo[1], q_ze[1]};

  // carry stands one cycle only, so catch it on every edge
  always @(posedge clk_i) begin
    if (cy_f === 1'b1) begin
      carries++;
      cy_flags = {up_f, lo_f, ze_f};
      cy_val = cnt;
    end
    if (q_cy[0] === 1'b1) begin
      qcarries++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // waits n edges, then lets that edge's updates land
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  task automatic cfg(input logic [31:0] v, u, l);
    @(posedge clk_i);
    iv <= v;
    ub <= u;
    lb <= l;
    q_iv <= {2{v}};
    q_ub <= {2{u}};
    q_lb <= {2{l}};
    @(posedge clk_i);
    ld <= 1'b1;
    q_ld <= 2'h3;
    @(posedge clk_i);
    ld <= 1'b0;
    q_ld <= 2'h0;
    wt(2);
  endtask : cfg

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(5000 * 25);
    err_count++;
    $display("BAD watchdog expected done seen timeout");
    summarize();
  end

  initial begin
    // inputs start idle; retentive bits low so reset clears the counts
    {resetn_i, run_i, dn, en, rel, ld, clr, ret} <= 8'h0;
    {ub, lb, iv} <= 96'h0;
    {q_en, q_rel, q_ld, q_clr, q_ret} <= 10'h0;
    {q_ub, q_lb, q_iv} <= 192'h0;
    rows[0] = '{32'h0, 32'ha, 32'hfffffffb, 3'h1};
    rows[1] = '{32'ha, 32'ha, 32'h0, 3'h4};
    rows[2] = '{32'hfffffffb, 32'ha, 32'hfffffffb, 3'h2};
    rows[3] = '{32'h0, 32'h0, 32'h0, 3'h7};
    rows[4] = '{32'h7fffffff, 32'h80000000, 32'h7fffffff, 3'h6};
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    run_i <= 1'b1;
    wt(1);
    chk("count after reset", 32'h0, cnt);
    chk("zero after reset", 32'h1, 32'(ze_f));
    // load table: upper, lower and zero flags of fast and both quad counters, value of fast and quad counter 1
    foreach (rows[i]) begin
      cfg(rows[i].iv, rows[i].ub, rows[i].lb);
      chk("fast load", rows[i].iv, cnt);
      chk("fast flags", 32'(rows[i].f), 32'({up_f, lo_f, ze_f}));
      chk("quad1 load", rows[i].iv, q_cnt[1]);
      chk("quad0 flags", 32'(rows[i].f), 32'(q0_f));
      chk("quad1 flags", 32'(rows[i].f), 32'(q1_f));
    end
    cfg(32'h0, 32'h3, 32'h1);
    src.pulses(3);
    wt(2);
    chk("count up", 32'h3, cnt);
    chk("upper flag", 32'h1, 32'(up_f));
    @(posedge clk_i);
    dn <= 1'b1;
    src.pulses(5);
    wt(2);
    chk("count down", 32'hfffffffe, cnt);
    chk("lower flag", 32'h1, 32'(lo_f));
    @(posedge clk_i);
    dn <= 1'b0;
    rel <= 1'b1;
    src.pulses(2);
    wt(2);
    chk("disabled count", 32'hfffffffe, cnt);
    @(posedge clk_i);
    en <= 1'b1;
    src.pulses(1);
    wt(2);
    chk("enabled count", 32'hffffffff, cnt);
    @(posedge clk_i);
    rel <= 1'b0;
    en <= 1'b0;
    src.pulses(1);
    wt(2);
    chk("always active", 32'h0, cnt);
    // clear and load together, clear held through a pulse
    @(posedge clk_i);
    iv <= 32'h5;
    clr <= 1'b1;
    ld <= 1'b1;
    src.pulses(1);
    wt(2);
    chk("clear beats load", 32'h0, cnt);
    chk("zero on clear", 32'h1, 32'(ze_f));
    @(posedge clk_i);
    clr <= 1'b0;
    ld <= 1'b0;
    // leaving range: bounds chosen so forced flags differ from normal
    cfg(32'h7fffffff, 32'h7fffffff, 32'h7fffffff);
    src.pulses(1);
    wt(2);
    chk("overflow hold", 32'h7fffffff, cnt);
    chk("carry pulses", 32'h1, 32'(carries));
    chk("carry flags up", 32'h4, 32'(cy_flags));
    chk("flags after", 32'h6, 32'({up_f, lo_f, ze_f}));
    // one quarter step up from the top of range on quad counter 0
    src.quad(0, 1'b1, 1);
    wt(2);
    chk("quad0 overflow hold", 32'h7fffffff, q_cnt[0]);
    chk("quad0 carry pulses", 32'h1, 32'(qcarries));
    cfg(32'h80000000, 32'h80000000, 32'h80000000);
    @(posedge clk_i);
    dn <= 1'b1;
    src.pulses(1);
    wt(2);
    chk("underflow hold", 32'h80000000, cy_val);
    chk("carry flags down", 32'h2, 32'(cy_flags));
    chk("carry count", 32'h2, 32'(carries));
    // retention over reset and over stop
    @(posedge clk_i);
    dn <= 1'b0;
    ret <= 1'b1;
    cfg(32'h5, 32'ha, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    wt(4);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    run_i <= 1'b0;
    wt(3);
    @(posedge clk_i);
    run_i <= 1'b1;
    wt(1);
    chk("retained", 32'h5, cnt);
    src.pulses(1);
    wt(2);
    chk("resume", 32'h6, cnt);
    // retentive count survives a run to stop change
    @(posedge clk_i);
    run_i <= 1'b0;
    wt(2);
    chk("kept over stop", 32'h6, cnt);
    @(posedge clk_i);
    run_i <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    run_i <= 1'b0;
    wt(2);
    chk("not retained", 32'h0, cnt);
    @(posedge clk_i);
    run_i <= 1'b1;
    // quadrature: both edges, both directions, channels fixed per counter
    cfg(32'h0, 32'h8, 32'hfffffffc);
    src.quad(0, 1'b1, 8);
    wt(2);
    chk("quad0 up", 32'h8, q_cnt[0]);
    chk("quad0 upper", 32'h1, 32'(q_up[0]));
    chk("quad1 idle", 32'h0, q_cnt[1]);
    src.quad(1, 1'b0, 4);
    wt(2);
    chk("quad1 down", 32'hfffffffc, q_cnt[1]);
    chk("quad1 lower", 32'h1, 32'(q_lo[1]));
    @(posedge clk_i);
    q_rel <= 2'h1;
    src.quad(0, 1'b0, 3);
    wt(2);
    chk("quad0 disabled", 32'h8, q_cnt[0]);
    // release option set and enable high: counting goes on
    @(posedge clk_i);
    q_en <= 2'h3;
    q_rel <= 2'h3;
    src.quad(0, 1'b0, 3);
    wt(2);
    chk("quad0 down", 32'h5, q_cnt[0]);
    // only the retentive quad counter keeps its count over a stop
    @(posedge clk_i);
    q_ret <= 2'h1;
    run_i <= 1'b0;
    wt(2);
    chk("quad0 retained", 32'h5, q_cnt[0]);
    chk("quad1 not retained", 32'h0, q_cnt[1]);
    @(posedge clk_i);
    run_i <= 1'b1;
    @(posedge clk_i);
    q_clr <= 2'h3;
    wt(2);
    chk("quad clear", 32'h0, q_cnt[0] | q_cnt[1]);
    summarize();
  end

endmodule : tb_fast_updown_quadrature_counter

`default_nettype wire
